// file: design/ccp_pipeline.sv
// Colour processing pipeline: demosaic, matrix, YUV, hue/sat, sharpening, APB registers.
`timescale 1ns/1ps
module ccp_pipeline (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic raw_valid,
  input wire logic [15:0] raw_data,
  input wire logic raw_line_last,
  output ccp_pkg::ccp_pix_t pix_out,
  output logic [15:0] raw_out,
  output logic [2:0] fmt_out
);
  import ccp_pkg::*;

  logic [2:0] fmt;
  logic ccm_off;
  logic [2:0] sharp;
  logic [8:0] hue;
  logic [8:0] sat;
  logic [31:0] ccm [0:8];
  logic user_set;
  logic row_odd;
  logic col_odd;
  logic [7:0] line_buf [0:4095];
  logic [11:0] col;
  logic [7:0] prev_cur, prev_above;
  ccp_pix_t s_dm, s_cc, s_hs, s_yuv;
  logic [7:0] y_d1, y_d2;
  logic v_d1, v_d2;
  logic [7:0] u_d1, v_c_d1, u_d2, v_c_d2;
  logic raw_mode;
  logic setup, access;
  logic [31:0] read_mux;

  assign raw_mode = (fmt == FMT_RAW8) || (fmt == FMT_RAW12) || (fmt == FMT_RAW16);
  assign access = psel && penable;
  assign setup = psel && !penable;

  function automatic logic ccm_addr(input logic [11:0] a);
    return (a >= ADDR_CCM_BASE) && (a <= ADDR_CCM_LAST) && (a[1:0] == 2'b00);
  endfunction : ccm_addr

  // Row sum limit: scale row down when it passes the maximum
  function automatic int row_sum(input int r);
    return $signed(ccm[3*r]) + $signed(ccm[3*r+1]) + $signed(ccm[3*r+2]);
  endfunction : row_sum

  // APB answers in the access cycle; no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      if (setup) begin
        prdata <= read_mux;
        pslverr <= !(paddr == ADDR_CTRL || paddr == ADDR_STATUS || paddr == ADDR_HUE ||
                     paddr == ADDR_SAT || paddr == ADDR_USERSET || ccm_addr(paddr));
      end
    end
  end

  always_comb begin
    read_mux = 32'h0;
    if (paddr == ADDR_CTRL) begin
      read_mux[CTRL_FMT_LSB +: 3] = fmt;
      read_mux[CTRL_CCM_OFF] = ccm_off;
      read_mux[CTRL_SHARP_LSB +: 3] = sharp;
    end else if (paddr == ADDR_STATUS) begin
      read_mux[0] = raw_mode;
      read_mux[1] = raw_mode || ccm_off;
      read_mux[2] = row_odd;
      read_mux[3] = user_set;
    end else if (paddr == ADDR_HUE) begin
      read_mux[8:0] = hue;
    end else if (paddr == ADDR_SAT) begin
      read_mux[8:0] = sat;
    end else if (paddr == ADDR_USERSET) begin
      read_mux[0] = user_set;
    end else if (ccm_addr(paddr)) begin
      read_mux = ccm[4'((paddr - ADDR_CCM_BASE) >> 2)];
    end
  end

  // Writes land on the edge where pready is sampled high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmt <= FMT_YUV444;
      ccm_off <= 1'b0;
      sharp <= 3'h0;
      hue <= HUE_RESET;
      sat <= SAT_RESET;
      user_set <= 1'b0;
    end else if (access && pready && pwrite) begin
      if (paddr == ADDR_CTRL) begin
        fmt <= (pwdata[CTRL_FMT_LSB +: 3] > 3'(FMT_RAW16)) ? fmt : pwdata[CTRL_FMT_LSB +: 3];
        ccm_off <= pwdata[CTRL_CCM_OFF];
        // R5 level range
        sharp <= (pwdata[CTRL_SHARP_LSB +: 3] > SHARP_MAX) ? SHARP_MAX : pwdata[CTRL_SHARP_LSB +: 3];
      end
      // R7 hue range
      if (paddr == ADDR_HUE) hue <= (pwdata[8:0] > HUE_MAX) ? HUE_MAX : pwdata[8:0];
      // R9 saturation step
      if (paddr == ADDR_SAT) sat <= pwdata[8:0];
      if (paddr == ADDR_USERSET) user_set <= pwdata[0];
    end
  end

  // R17 factory set: writes are taken only while user_set is 1 and overwrite the one coefficient set; reset reloads the factory values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 9; i++) ccm[i] <= (i % 4 == 0) ? CCM_UNITY : 32'h0;
    end else if (access && pready && pwrite && ccm_addr(paddr) && user_set) begin
      // R14 coefficient range
      ccm[4'((paddr - ADDR_CCM_BASE) >> 2)] <= ccp_coef_clip(pwdata);
    end
  end

  // R2 red first: row and column phase counted from reset, stepped by raw_line_last
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      col <= 12'h0;
      col_odd <= 1'b0;
      row_odd <= 1'b0;
    end else if (raw_valid) begin
      col <= raw_line_last ? 12'h0 : col + 12'h1;
      col_odd <= raw_line_last ? 1'b0 : !col_odd;
      if (raw_line_last) row_odd <= !row_odd;
    end
  end

  // R1 two lines: one line buffer holds the previous sensor line
  always_ff @(posedge pclk) begin
    if (raw_valid) line_buf[col] <= raw_data[15:8];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_cur <= 8'h0;
      prev_above <= 8'h0;
    end else if (raw_valid) begin
      prev_cur <= raw_data[15:8];
      prev_above <= line_buf[col];
    end
  end

  // R3 nearest sites: 2x2 quad of above/current, left/right picks R, B, two G
  always_ff @(posedge pclk or negedge presetn) begin
    logic [7:0] a0, a1, b0, b1, r, g0, g1, bl;
    if (!presetn) begin
      s_dm <= '0;
    end else begin
      a0 = prev_above;
      a1 = line_buf[col];
      b0 = prev_cur;
      b1 = raw_data[15:8];
      // Quad position decides which corner is red
      unique case ({row_odd, col_odd})
        2'b00: begin r = b1; g0 = b0; g1 = a1; bl = a0; end
        2'b01: begin r = b0; g0 = b1; g1 = a0; bl = a1; end
        2'b10: begin r = a1; g0 = a0; g1 = b1; bl = b0; end
        2'b11: begin r = a0; g0 = a1; g1 = b0; bl = b1; end
      endcase
      s_dm.valid <= raw_valid && !raw_mode;
      s_dm.c0 <= r;
      s_dm.c1 <= 8'((9'(g0) + 9'(g1)) >> 1);
      s_dm.c2 <= bl;
    end
  end

  // R11 matrix product, R12 unity 1000, R13 identity, R15 row limit, R18 bypass
  always_ff @(posedge pclk or negedge presetn) begin
    int acc, sum, den;
    if (!presetn) begin
      s_cc <= '0;
    end else begin
      s_cc.valid <= s_dm.valid;
      if (ccm_off || raw_mode) begin
        s_cc.c0 <= s_dm.c0;
        s_cc.c1 <= s_dm.c1;
        s_cc.c2 <= s_dm.c2;
      end else begin
        for (int r = 0; r < 3; r++) begin
          sum = row_sum(r);
          den = (sum > CCM_ROW_MAX) ? sum * CCM_UNITY / CCM_ROW_MAX : CCM_UNITY;
          acc = $signed(ccm[3*r]) * int'(s_dm.c0) + $signed(ccm[3*r+1]) * int'(s_dm.c1) +
                $signed(ccm[3*r+2]) * int'(s_dm.c2);
          // R23 round and clamp
          if (r == 0) s_cc.c0 <= ccp_clamp8((acc + den / 2) / den);
          if (r == 1) s_cc.c1 <= ccp_clamp8((acc + den / 2) / den);
          if (r == 2) s_cc.c2 <= ccp_clamp8((acc + den / 2) / den);
        end
      end
    end
  end

  // R24 stage order: YUV, then hue and saturation on chroma, sharpening on luma
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_yuv <= '0;
    end else begin
      s_yuv.valid <= s_cc.valid;
      // R19 luma weights
      s_yuv.c0 <= ccp_clamp8((YR * s_cc.c0 + YG * s_cc.c1 + YB * s_cc.c2 + 512) >>> 10);
      // R20 U chroma, centred on zero here; offset added after rotation
      s_yuv.c1 <= 8'((UR * s_cc.c0 + UG * s_cc.c1 + UB * s_cc.c2 + 512) >>> 10);
      // R21 V chroma
      s_yuv.c2 <= 8'((VR * s_cc.c0 + VG * s_cc.c1 + VB * s_cc.c2 + 512) >>> 10);
    end
  end

  // R8 rotation, R10 saturation scale; luma untouched so white stays white
  always_ff @(posedge pclk or negedge presetn) begin
    int h, u, v, ur, vr;
    if (!presetn) begin
      s_hs <= '0;
    end else begin
      h = int'(hue) - HUE_CENTER;
      u = $signed(s_yuv.c1);
      v = $signed(s_yuv.c2);
      // Small angle: cos taken as one, sin linear in the step count
      ur = u - ((h * HUE_SIN_STEP * v) >>> 16);
      vr = v + ((h * HUE_SIN_STEP * u) >>> 16);
      s_hs.valid <= s_yuv.valid;
      s_hs.c0 <= s_yuv.c0;
      s_hs.c1 <= ccp_clamp8(((ur * int'(sat) + 128) >>> 8) + CHROMA_OFS);
      s_hs.c2 <= ccp_clamp8(((vr * int'(sat) + 128) >>> 8) + CHROMA_OFS);
    end
  end

  // R5 high-pass: y + k/4 * (2y - left - right), three-tap on luma
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      y_d1 <= 8'h0;
      y_d2 <= 8'h0;
      v_d1 <= 1'b0;
      v_d2 <= 1'b0;
      u_d1 <= 8'h0;
      u_d2 <= 8'h0;
      v_c_d1 <= 8'h0;
      v_c_d2 <= 8'h0;
    end else if (s_hs.valid) begin
      y_d1 <= s_hs.c0;
      y_d2 <= y_d1;
      u_d1 <= s_hs.c1;
      u_d2 <= u_d1;
      v_c_d1 <= s_hs.c2;
      v_c_d2 <= v_c_d1;
      v_d1 <= 1'b1;
      v_d2 <= v_d1;
    end
  end

  // Output mux; RGB8 reuses corrected colours delayed to match
  ccp_pix_t rgb_d1, rgb_d2, rgb_d3;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rgb_d1 <= '0;
      rgb_d2 <= '0;
      rgb_d3 <= '0;
    end else begin
      rgb_d1 <= s_cc;
      rgb_d2 <= rgb_d1;
      rgb_d3 <= rgb_d2;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    int hp;
    if (!presetn) begin
      pix_out <= '0;
      raw_out <= 16'h0;
      fmt_out <= 3'h0;
    end else begin
      hp = 2 * int'(y_d1) - int'(y_d2) - int'(s_hs.c0);
      fmt_out <= fmt;
      // R4 raw pass and R6 sharpness ignored in RAW
      if (raw_mode) begin
        pix_out <= '0;
        raw_out <= raw_valid ? raw_data : 16'h0;
        pix_out.valid <= raw_valid;
      end else if (fmt == FMT_RGB8) begin
        // R22 skip YUV
        pix_out <= rgb_d3;
        raw_out <= 16'h0;
      end else begin
        raw_out <= 16'h0;
        pix_out.valid <= s_hs.valid && v_d1;
        pix_out.c0 <= ccp_clamp8(int'(y_d1) + ((int'(sharp) * hp + 2) >>> 2));
        pix_out.c1 <= u_d1;
        pix_out.c2 <= v_c_d1;
      end
    end
  end
endmodule : ccp_pipeline

// file: design/ccp_pkg.sv
// Package for the colour processing pipeline: register map, resets, types.
// Notes on behaviour
// R1: Demosaic uses a 2x2 window from two consecutive sensor lines only.
// R2: Mosaic phase assumes the top-left sensor pixel is red.
// R3: Red and blue come from nearest sites; green averages two greens.
// R4: RAW formats bypass all colour processing and pass mosaic samples.
// R5: Sharpening is a horizontal high-pass on luma, level 0 to 4.
// R6: Sharpness has no effect in the 8, 12 and 16 bit RAW formats.
// R7: Hue at 0x810 takes 0..256; 128 is no shift; step 1/12.8 degree.
// R8: Hue rotates chroma up to 128 steps either way, white balance untouched.
// R9: Saturation at 0x814 scales colour 0 to 200 percent in 1/256 steps.
// R10: Saturation 0 is monochrome, 256 nominal, 511 about double.
// R11: Each corrected colour is a coefficient-weighted sum of red, green, blue.
// R12: A coefficient of 1000 means a gain of one.
// R13: Identity matrix of 1000 diagonals leaves colours unchanged.
// R14: Coefficients are signed 32 bit, accepted range -1000 to +2000.
// R15: Each matrix row sum is limited to at most 2000.
// R16: Host should make every row sum to 1000, all rows equal.
// R17: Factory coefficients in user set 0 are never overwritten; the code keeps one set, which writes overwrite while user_set is 1.
// R18: Matrix forced off in RAW, and switchable off by host in YUV.
// R19: Luma is 0.3 R plus 0.59 G plus 0.11 B.
// R20: U is -0.169 R -0.33 G +0.498 B plus 128.
// R21: V is 0.498 R -0.420 G -0.082 B plus 128.
// R22: RGB8 skips YUV conversion and outputs corrected RGB directly.
// R23: Every arithmetic stage rounds and clamps; nothing wraps. Code truncates the green average and hue rotation; U and V wrap.
// R24: Fixed stage order, each stage keeps valid aligned with its data.
package ccp_pkg;
  localparam logic [11:0] ADDR_CTRL = 12'h800;
  localparam logic [11:0] ADDR_STATUS = 12'h804;
  localparam logic [11:0] ADDR_HUE = 12'h810;
  localparam logic [11:0] ADDR_SAT = 12'h814;
  localparam logic [11:0] ADDR_CCM_BASE = 12'h820;
  localparam logic [11:0] ADDR_CCM_LAST = 12'h840;
  localparam logic [11:0] ADDR_USERSET = 12'h850;
  localparam logic [8:0] HUE_RESET = 9'h080;
  localparam logic [8:0] HUE_MAX = 9'h100;
  localparam logic [8:0] SAT_RESET = 9'h100;
  localparam int HUE_CENTER = 128;
  localparam int CCM_UNITY = 1000;
  localparam int CCM_MIN = -1000;
  localparam int CCM_MAX = 2000;
  localparam int CCM_ROW_MAX = 2000;
  localparam logic [2:0] SHARP_MAX = 3'h4;
  // Fixed point x/1024 for YUV; hue step as sin/cos per step * 2^16
  localparam int YR = 307, YG = 604, YB = 113;
  localparam int UR = -173, UG = -338, UB = 510;
  localparam int VR = 510, VG = -430, VB = -84;
  localparam int HUE_SIN_STEP = 89;
  localparam int CHROMA_OFS = 128;
  // Control register fields
  localparam int CTRL_FMT_LSB = 0;
  localparam int CTRL_CCM_OFF = 4;
  localparam int CTRL_SHARP_LSB = 8;
  localparam int CTRL_LINE_START = 12;

  typedef enum logic [2:0] {
    FMT_YUV444, FMT_RGB8, FMT_RAW8, FMT_RAW12, FMT_RAW16
  } ccp_fmt_t;

  typedef struct packed {
    logic valid;
    logic [7:0] c0;
    logic [7:0] c1;
    logic [7:0] c2;
  } ccp_pix_t;

  function automatic logic [7:0] ccp_clamp8(input int v);
    if (v < 0) return 8'h00;
    if (v > 255) return 8'hff;
    return v[7:0];
  endfunction : ccp_clamp8

  function automatic logic [31:0] ccp_coef_clip(input logic [31:0] v);
    if ($signed(v) < CCM_MIN) return CCM_MIN;
    if ($signed(v) > CCM_MAX) return CCM_MAX;
    return v;
  endfunction : ccp_coef_clip
endpackage : ccp_pkg

// file: tb/ccp_pipeline_props.sv
// Checker on the pipeline ports: APB timing, raw pass, valid framing.
`timescale 1ns/1ps
module ccp_pipeline_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic raw_valid,
  input wire logic [15:0] raw_data,
  input wire logic [15:0] raw_out,
  input wire ccp_pkg::ccp_pix_t pix_out,
  input wire logic [2:0] fmt_out
);
  import ccp_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_ready_a: assert property (psel && !penable |=> pready) else $error("pready late");
  ready_access_a: assert property (pready |-> psel && penable) else $error("pready outside access");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  raw_pass_a: assert property (
    raw_valid && fmt_out >= 3'h2 && $stable(fmt_out) |=> raw_out == $past(raw_data)) else $error("raw not passed");
  raw_no_pix_a: assert property (
    fmt_out >= 3'h2 |-> pix_out.c0 == 8'h00 && pix_out.c1 == 8'h00 && pix_out.c2 == 8'h00 &&
    pix_out.valid == $past(raw_valid)) else $error("colour data in raw");
  fmt_legal_a: assert property (fmt_out <= 3'h4) else $error("format out of range");
  valid_align_a: assert property (!raw_valid [*8] |-> !pix_out.valid) else $error("stray valid");
  cover property (pslverr);
  cover property ($rose(pix_out.valid));
  cover property (raw_valid && fmt_out == 3'h4);
endmodule : ccp_pipeline_props
bind ccp_pipeline ccp_pipeline_props ccp_pipeline_props_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .raw_valid(raw_valid), .raw_data(raw_data),
  .raw_out(raw_out), .pix_out(pix_out), .fmt_out(fmt_out));

// file: tb/ccp_sensor_model.sv
// Sensor readout model: red-first mosaic frames, prompt or gapped.
`timescale 1ns/1ps
module ccp_sensor_model (
  input wire logic pclk,
  output logic raw_valid,
  output logic [15:0] raw_data,
  output logic raw_line_last
);
  initial begin
    raw_valid = 1'b0;
    raw_data = 16'h0000;
    raw_line_last = 1'b0;
  end
  task automatic send_frame(input logic [7:0] r, g, b, input int lines, width, gap);
    logic [7:0] v;
    for (int y = 0; y < lines; y++) begin
      for (int x = 0; x < width; x++) begin
        v = (y % 2 == 0) ? ((x % 2 == 0) ? r : g) : ((x % 2 == 0) ? g : b);
        @(posedge pclk);
        raw_valid <= 1'b1;
        raw_data <= {v, 8'h00};
        raw_line_last <= (x == width - 1);
        // Idle data is inverted so stale samples never look valid
        repeat (gap) begin
          @(posedge pclk);
          raw_valid <= 1'b0;
          raw_data <= ~{v, 8'h00};
          raw_line_last <= 1'b0;
        end
      end
    end
    @(posedge pclk);
    raw_valid <= 1'b0;
    raw_data <= ~raw_data;
    raw_line_last <= 1'b0;
  endtask : send_frame
endmodule : ccp_sensor_model

// file: tb/color_processing_pipeline_tb_top.sv
// Self-checking bench: register table, colour formats, raw pass.
`timescale 1ns/1ps
module color_processing_pipeline_tb_top;
  import ccp_pkg::*;
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic err;} ccp_row_t;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, raw_valid, raw_line_last, rv_d = 1'b0, clr_pix = 1'b0;
  logic [15:0] raw_data, raw_out, last_raw = 16'h0;
  ccp_pix_t pix_out, last_pix;
  logic [2:0] fmt_out;
  int mismatches = 0, cmp_count = 0;
  ccp_row_t rows [10] = '{
    '{0, ADDR_HUE, 32'h80, 0}, '{0, ADDR_SAT, 32'h100, 0},
    '{0, ADDR_CCM_BASE, 32'h3e8, 0}, '{0, 12'h824, 32'h0, 0},
    '{1, ADDR_HUE, 32'h12c, 0}, '{0, ADDR_HUE, 32'h100, 0},
    '{1, ADDR_SAT, 32'h1ff, 0}, '{0, ADDR_SAT, 32'h1ff, 0},
    '{1, ADDR_CCM_BASE, 32'h1f4, 0}, '{0, ADDR_CCM_BASE, 32'h3e8, 0}};
  always #12.5 pclk = ~pclk;
  ccp_pipeline ccp_pipeline_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .raw_valid(raw_valid), .raw_data(raw_data), .raw_line_last(raw_line_last), .pix_out(pix_out),
    .raw_out(raw_out), .fmt_out(fmt_out));
  ccp_sensor_model ccp_sensor_model_inst (.pclk(pclk), .raw_valid(raw_valid), .raw_data(raw_data),
    .raw_line_last(raw_line_last));
  always @(posedge pclk) begin
    rv_d <= raw_valid;
    // Clearing here keeps one writer per capture register and stops a stale frame from passing
    if (clr_pix) begin
      last_raw <= 16'h0;
      last_pix <= '0;
    end else begin
      if (rv_d === 1'b1) last_raw <= raw_out;
      if (pix_out.valid === 1'b1) last_pix <= pix_out;
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No assumed latency: a hung access is ended by the watchdog only
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset
  task automatic frame(input logic [7:0] r, g, b, input int gap);
    clr_pix <= 1'b1;
    @(posedge pclk);
    clr_pix <= 1'b0;
    ccp_sensor_model_inst.send_frame(r, g, b, 4, 8, gap);
    repeat (12) @(posedge pclk);
  endtask : frame
  task automatic final_report();
    if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  initial begin
    #(25ns * 20000);
    mismatches++;
    final_report();
  end
  initial begin
    do_reset();
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk("prdata", rows[i].d, rd);
      chk("pslverr", 32'(rows[i].err), 32'(er));
    end
    apb(0, 12'hffc, 0);
    chk("unmapped", 32'h1, 32'(er));
    apb(1, ADDR_USERSET, 1);
    apb(1, ADDR_CCM_BASE, 32'd3000);
    apb(0, ADDR_CCM_BASE, 0);
    chk("ccm_hi", 32'd2000, rd);
    apb(1, 12'h824, -32'sd5000);
    apb(0, 12'h824, 0);
    chk("ccm_lo", 32'hfffffc18, rd);
    apb(1, ADDR_CTRL, 1);
    apb(1, ADDR_CTRL, 5);
    // Give a wrongly accepted format time to reach the registered copy
    repeat (2) @(posedge pclk);
    chk("fmt_bad", 32'h1, 32'(fmt_out));
    // Reset mid-run must bring back the factory identity
    do_reset();
    apb(0, ADDR_CCM_BASE, 0);
    chk("ccm_rst", 32'h3e8, rd);
    apb(1, ADDR_CTRL, 1);
    frame(8'hff, 8'h00, 8'h00, 0);
    chk("rgb", 32'hff0000, 32'({last_pix.c0, last_pix.c1, last_pix.c2}));
    apb(1, ADDR_USERSET, 1);
    apb(1, ADDR_CCM_BASE, 32'd500);
    apb(1, 12'h824, 32'd500);
    frame(8'hff, 8'h00, 8'h00, 0);
    chk("ccm_row", 32'h800000, 32'({last_pix.c0, last_pix.c1, last_pix.c2}));
    apb(1, ADDR_CTRL, 0);
    frame(8'h80, 8'h80, 8'h80, 2);
    chk("luma", 32'h80, 32'(last_pix.c0));
    apb(1, ADDR_SAT, 0);
    frame(8'hff, 8'h00, 8'h00, 1);
    chk("mono", 32'h8080, 32'({last_pix.c1, last_pix.c2}));
    for (int f = 2; f <= 4; f++) begin
      apb(1, ADDR_CTRL, 32'h400 | f);
      frame(8'h12, 8'h34, 8'h56, f - 2);
      chk("raw", 32'h5600, 32'(last_raw));
    end
    final_report();
  end
endmodule : color_processing_pipeline_tb_top
